// file: bench/cpw_top_chk.sv
/* Port checker for cpw_top.
 Assumes it is bound to every cpw_top instance. */
`timescale 1ns/100ps
`default_nettype none
module cpw_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Interrupt
	input wire logic irq
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	wire wr_acc = psel && penable && pwrite;

	// Zero wait states, one-cycle answer
	a_ready_first: assert property (psel && !penable |=> pready) else $error("late ready");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held");
	// Decode: only the mapped words answer cleanly
	a_err_map: assert property (pready && paddr > 8'h34 |-> pslverr) else $error("no error");
	a_ok_map: assert property (pready && paddr <= 8'h34 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("false error");
	a_err_data: assert property (pslverr |-> pready && prdata == 32'h0) else $error("err data");
	a_read_hi: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
		else $error("upper bits");
	// Sticky status: irq only drops after a status or mask write
	a_irq_clear: assert property ($fell(irq) |-> $past(wr_acc)) else $error("irq dropped");
endmodule // cpw_chk

bind cpw_top cpw_chk cpw_chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: bench/cpw_top_test.sv
/* Self-checking bench for cpw_top.
 Assumes the port checker is bound from its own file. */
`include "cpw_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module cpw_top_test;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [2:0] pwm_pos;
	logic [2:0] pwm_neg;
	logic [31:0] rd;
	logic err;
	int error_cnt = 0;
	int samples_checked = 0;

	cpw_top cpw_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .pwm_pos(pwm_pos), .pwm_neg(pwm_neg));

	// 25 MHz
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, idle edge after it so calls never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
			$display("BAD %0t no ready", $time);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'h0, d});
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Poll until the count does or does not show v
	task automatic wt(input logic [7:0] a, input logic [15:0] v, input logic eq);
		int n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rd[15:0] === v) !== eq && n < 300);
		if ((rd[15:0] === v) !== eq) begin
			error_cnt++;
			$display("BAD %0t poll limit", $time);
		end
	endtask

	// Stop, clear mode, select it, preload period 4, buffers last
	task automatic cfg(input logic [1:0] m, input logic [15:0] ba, input logic [15:0] bb);
		wr(`CPW_OFS_START, 16'h0);
		wr(`CPW_OFS_FCR, 16'h0);
		wr(`CPW_OFS_FCR, {14'h0, m});
		wr(`CPW_OFS_STATUS, 16'h7);
		wr(`CPW_OFS_PERIOD, 16'h4);
		wr(`CPW_OFS_PRESCALE, 16'h7);
		wr(`CPW_OFS_CNT0, 16'h1);
		wr(`CPW_OFS_CNT1, 16'h0);
		wr(`CPW_OFS_ACT_A, 16'h1);
		wr(`CPW_OFS_ACT_B, 16'h1);
		wr(`CPW_OFS_ACT_C, 16'h1);
		wr(`CPW_OFS_BUF_A, ba);
		wr(`CPW_OFS_BUF_B, bb);
		wr(`CPW_OFS_BUF_C, 16'h2);
		wr(`CPW_OFS_FCR, {9'h0, 3'h7, 2'h0, m});
		wr(`CPW_OFS_START, 16'h3);
	endtask

	task automatic t_reset();
		rc(`CPW_OFS_FCR, 32'h0);
		rc(`CPW_OFS_PERIOD, 32'h0000ffff);
		rc(8'h38, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk({26'h0, pwm_pos, pwm_neg}, 32'h0);
	endtask

	// Turnarounds, flags, frozen period, stopped pin levels
	task automatic t_count();
		cfg(2'b11, 16'h2, 16'h3);
		wt(`CPW_OFS_CNT0, 16'h5, 1'b1);
		rc(`CPW_OFS_STATUS, 32'h1);
		wr(`CPW_OFS_PERIOD, 16'h9);
		rc(`CPW_OFS_PERIOD, 32'h4);
		wt(`CPW_OFS_CNT0, 16'h5, 1'b0);
		chk(rd, 32'h4);
		wr(`CPW_OFS_STATUS, 16'h7);
		wt(`CPW_OFS_CNT1, 16'hffff, 1'b1);
		rc(`CPW_OFS_STATUS, 32'h2);
		wt(`CPW_OFS_CNT1, 16'hffff, 1'b0);
		chk(rd, 32'h0);
		chk({26'h0, pwm_pos, pwm_neg}, 32'h38);
		wr(`CPW_OFS_START, 16'h0);
		wr(`CPW_OFS_FCR, 16'h000f);
		repeat (2) @(posedge clk_sys);
		chk({26'h0, pwm_pos, pwm_neg}, 32'h3f);
	endtask

	// A at period, B zero, C in range; then both back in range
	task automatic t_force(input logic [1:0] m);
		cfg(m, 16'h4, 16'h0);
		wt(`CPW_OFS_CNT0, 16'h5, 1'b1);
		rc(`CPW_OFS_ACT_A, 32'h1);
		rc(`CPW_OFS_ACT_B, 32'h0);
		rc(`CPW_OFS_ACT_C, m[0] ? 32'h2 : 32'h1);
		wt(`CPW_OFS_CNT1, 16'hffff, 1'b1);
		rc(`CPW_OFS_ACT_A, 32'h4);
		rc(`CPW_OFS_ACT_C, 32'h2);
		wr(`CPW_OFS_FCR, {14'h0, m});
		wr(`CPW_OFS_BUF_A, 16'h3);
		wr(`CPW_OFS_BUF_B, 16'h1);
		wr(`CPW_OFS_FCR, {9'h0, 3'h7, 2'h0, m});
		wt(`CPW_OFS_CNT0, 16'h5, 1'b1);
		rc(`CPW_OFS_ACT_A, 32'h4);
		rc(`CPW_OFS_ACT_B, 32'h1);
		wt(`CPW_OFS_CNT1, 16'hffff, 1'b1);
		rc(`CPW_OFS_ACT_A, 32'h3);
	endtask

	// Raise, mask, unmask and clear the underflow interrupt
	task automatic t_irq();
		int n = 0;
		wr(`CPW_OFS_STATUS, 16'h7);
		wr(`CPW_OFS_MASK, 16'h2);
		while (irq !== 1'b1 && n < 400) begin
			@(posedge clk_sys);
			n++;
		end
		wr(`CPW_OFS_START, 16'h0);
		chk({31'h0, irq}, 32'h1);
		wr(`CPW_OFS_MASK, 16'h0);
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		wr(`CPW_OFS_MASK, 16'h2);
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h1);
		wr(`CPW_OFS_STATUS, 16'h2);
		@(posedge clk_sys);
		chk({31'h0, irq}, 32'h0);
		wr(`CPW_OFS_FCR, 16'h0);
		wr(`CPW_OFS_CNT0, 16'h1);
		wr(`CPW_OFS_START, 16'h3);
		repeat (20) @(posedge clk_sys);
		rc(`CPW_OFS_CNT0, 32'h1);
		chk({26'h0, pwm_pos, pwm_neg}, 32'h0);
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_count();
		t_force(2'b11);
		t_force(2'b10);
		t_irq();
		tally_and_finish();
	end

	// Watchdog at 20000 cycles, far beyond the under two thousand cycles needed
	initial begin
		#800000;
		error_cnt++;
		tally_and_finish();
	end
endmodule // cpw_top_test
`default_nettype wire

// file: rtl/cpw_counter_pair.sv
/*
 * Counter pair: counter0 and counter1 step together up and down,
 * counter1 trailing by the dead-time offset loaded before start.
 * Assumes one clock; counting is paced by an internal prescale divider.
 */
`include "cpw_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cpw_counter_pair (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Control
	input wire logic run,
	input wire logic [15:0] period,
	input wire logic [15:0] prescale,
	// Software counter writes, honoured while stopped
	input wire logic wr_c0,
	input wire logic wr_c1,
	input wire logic [15:0] wdata,
	// Counter values and step events
	output cpw_pkg::cpw_cnt_t cnt,
	output cpw_pkg::cpw_evt_t evt
);

	cpw_pkg::cpw_pair_st_t st_q, st_d;
	logic [15:0] m_plus1;

	assign m_plus1 = period + `CPW_ONE16;

	// Next state of the pair
	always_comb begin
		st_d = st_q;
		st_d.evt = '0;
		if (!run) begin
			// Stopped: always restart counting upward
			st_d.dir = cpw_pkg::CPW_UP;
			st_d.div = `CPW_ZERO16;
			if (wr_c0) begin
				st_d.cnt.c0 = wdata;
			end
			if (wr_c1) begin
				st_d.cnt.c1 = wdata;
			end
		end else if (st_q.div != prescale) begin
			st_d.div = st_q.div + `CPW_ONE16;
		end else begin
			st_d.div = `CPW_ZERO16;
			if (st_q.dir == cpw_pkg::CPW_UP) begin
				if (st_q.cnt.c0 == m_plus1) begin
					// Turn round at m+1: next value is m again
					st_d.dir = cpw_pkg::CPW_DOWN;
					st_d.cnt.c0 = st_q.cnt.c0 - `CPW_ONE16;
					st_d.cnt.c1 = st_q.cnt.c1 - `CPW_ONE16;
				end else begin
					st_d.cnt.c0 = st_q.cnt.c0 + `CPW_ONE16;
					st_d.cnt.c1 = st_q.cnt.c1 + `CPW_ONE16;
					// Only the m to m+1 step flags a match
					st_d.evt.cm = (st_q.cnt.c0 == period);
					st_d.evt.ovf = (st_q.cnt.c0 == `CPW_CNT_MAX);
				end
			end else begin
				if (st_q.cnt.c1 == `CPW_CNT_MAX) begin
					// Turn round below zero; the FFFFh to 0 wrap leaves overflow alone
					st_d.dir = cpw_pkg::CPW_UP;
					st_d.cnt.c0 = st_q.cnt.c0 + `CPW_ONE16;
					st_d.cnt.c1 = `CPW_ZERO16;
				end else begin
					st_d.cnt.c0 = st_q.cnt.c0 - `CPW_ONE16;
					st_d.cnt.c1 = st_q.cnt.c1 - `CPW_ONE16;
					st_d.evt.uf = (st_q.cnt.c1 == `CPW_ZERO16);
				end
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.dir <= cpw_pkg::CPW_UP;
		end else begin
			st_q <= st_d;
		end
	end

	assign cnt = st_q.cnt;
	assign evt = st_q.evt;

endmodule // cpw_counter_pair

`default_nettype wire

// file: rtl/cpw_duty_chan.sv
/*
 * One duty channel: active compare register, buffered transfer with
 * forced-timing exceptions, and the two compare decisions.
 * Assumes step events arrive as one-cycle pulses with the new counts.
 */
`include "cpw_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cpw_duty_chan (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Mode and configuration
	input wire logic running,
	input wire logic sel_cm,
	input wire logic buf_en,
	input wire logic [15:0] period,
	input wire logic [15:0] buf_val,
	// Software write of the active register
	input wire logic sw_wr,
	input wire logic [15:0] wdata,
	// Counter pair
	input wire cpw_pkg::cpw_cnt_t cnt,
	input wire cpw_pkg::cpw_evt_t evt,
	// Results
	output logic [15:0] active,
	output logic pos_on,
	output logic neg_on
);

	cpw_pkg::cpw_chan_st_t st_q, st_d;
	logic xfer;

	// Transfer timing and forced-timing memory
	always_comb begin
		st_d = st_q;
		xfer = 1'b0;
		if (running && buf_en) begin
			if (buf_val >= period) begin
				xfer = evt.uf;
				if (evt.uf) begin
					st_d.frc = cpw_pkg::CPW_HOLD_UF;
				end
			end else if (buf_val == `CPW_ZERO16) begin
				xfer = evt.cm;
				if (evt.cm) begin
					st_d.frc = cpw_pkg::CPW_HOLD_CM;
				end
			end else begin
				case (st_q.frc)
					cpw_pkg::CPW_HOLD_UF: begin
						xfer = evt.uf;
						if (evt.uf) begin
							st_d.frc = cpw_pkg::CPW_FREE;
						end
					end
					cpw_pkg::CPW_HOLD_CM: begin
						xfer = evt.cm;
						if (evt.cm) begin
							st_d.frc = cpw_pkg::CPW_FREE;
						end
					end
					// Selected timing; events fire once per turnaround
					cpw_pkg::CPW_FREE: begin
						xfer = sel_cm ? evt.cm : evt.uf;
					end
					default: begin
						st_d.frc = cpw_pkg::CPW_FREE;
					end
				endcase
			end
		end else if (!running) begin
			st_d.frc = cpw_pkg::CPW_FREE;
		end
		if (xfer) begin
			st_d.active = buf_val;
		end else if (sw_wr && !running) begin
			// Direct writes ignored while running
			st_d.active = wdata;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Positive phase uses the leading counter, negative the trailing one
	assign active = st_q.active;
	assign pos_on = (cnt.c0 < st_q.active);
	assign neg_on = (cnt.c1 != `CPW_CNT_MAX) && (cnt.c1 >= st_q.active);

endmodule // cpw_duty_chan

`default_nettype wire

// file: rtl/cpw_pkg.sv
/*
 * Types shared by the complementary PWM timer pair.
 * Assumes cpw_regs.svh for all numeric constants.
 */
package cpw_pkg;

	// Direction of the counter pair
	typedef enum logic {
		CPW_DOWN = 1'b0,
		CPW_UP = 1'b1
	} cpw_dir_t;

	// Per-channel forced transfer state
	typedef enum logic [1:0] {
		CPW_FREE = 2'b00,
		CPW_HOLD_UF = 2'b01,
		CPW_HOLD_CM = 2'b10
	} cpw_force_t;

	typedef struct packed {
		logic [15:0] c0;
		logic [15:0] c1;
	} cpw_cnt_t;

	typedef struct packed {
		logic cm;
		logic uf;
		logic ovf;
	} cpw_evt_t;

	typedef struct packed {
		logic [1:0] mode;
		logic lvl_pos;
		logic lvl_neg;
		logic [2:0] buf_sel;
	} cpw_fcr_t;

	typedef struct packed {
		cpw_cnt_t cnt;
		cpw_dir_t dir;
		logic [15:0] div;
		cpw_evt_t evt;
	} cpw_pair_st_t;

	typedef struct packed {
		logic [15:0] active;
		cpw_force_t frc;
	} cpw_chan_st_t;

	typedef struct packed {
		cpw_fcr_t fcr;
		logic run0;
		logic run1;
		logic [2:0] sts;
		logic [2:0] mask;
		logic [15:0] period;
		logic [15:0] prescale;
		logic [2:0][15:0] bufv;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
		logic [2:0] pos;
		logic [2:0] neg;
	} cpw_top_st_t;

endpackage

// file: rtl/cpw_regs.svh
/*
 * Register map, field positions, reset values and constants of the
 * complementary PWM timer pair.
 * Assumes APB with byte addresses and one 32-bit word per register.
 */
`ifndef CPW_REGS_SVH
`define CPW_REGS_SVH

// Register byte offsets
`define CPW_ADDR_W 8
`define CPW_OFS_FCR 8'h00
`define CPW_OFS_START 8'h04
`define CPW_OFS_STATUS 8'h08
`define CPW_OFS_MASK 8'h0c
`define CPW_OFS_PERIOD 8'h10
`define CPW_OFS_CNT0 8'h14
`define CPW_OFS_CNT1 8'h18
`define CPW_OFS_ACT_A 8'h1c
`define CPW_OFS_ACT_B 8'h20
`define CPW_OFS_ACT_C 8'h24
`define CPW_OFS_BUF_A 8'h28
`define CPW_OFS_BUF_B 8'h2c
`define CPW_OFS_BUF_C 8'h30
`define CPW_OFS_PRESCALE 8'h34

// Function control fields
`define CPW_FCR_MODE_LO 0
`define CPW_FCR_MODE_HI 1
`define CPW_FCR_LVL_POS 2
`define CPW_FCR_LVL_NEG 3
`define CPW_FCR_BSEL_LO 4
`define CPW_FCR_BSEL_HI 6

// Start control fields
`define CPW_START_RUN0 0
`define CPW_START_RUN1 1

// Status and mask fields
`define CPW_ST_PMATCH 0
`define CPW_ST_UNDER 1
`define CPW_ST_OVER 2
`define CPW_ST_W 3

// Combination mode encodings
`define CPW_MODE_PLAIN 2'b00
`define CPW_MODE_XFER_UF 2'b10
`define CPW_MODE_XFER_CM 2'b11

// Reset values and counter constants
`define CPW_PERIOD_RST 16'hffff
`define CPW_ZERO16 16'h0000
`define CPW_ONE16 16'h0001
`define CPW_CNT_MAX 16'hffff
`define CPW_DATA_W 16
`define CPW_NCH 3

`endif

// file: rtl/cpw_top.sv
/*
 * Complementary PWM timer pair: APB register file, counter pair,
 * three duty channels, sticky status with masked interrupt, and pins.
 * Assumes an APB master on clk_sys; pins are plain push-pull outputs.
 * Outputs are registered; a port checker may be bound to them.
 */
`include "cpw_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module cpw_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Motor-control pins
	output logic [2:0] pwm_pos,
	output logic [2:0] pwm_neg
);

	// Whole register state of the block
	cpw_pkg::cpw_top_st_t st_q, st_d;

	// Counter pair and channel results
	cpw_pkg::cpw_cnt_t cnt;
	cpw_pkg::cpw_evt_t evt;
	logic [2:0][15:0] act;
	logic [2:0] pos_on;
	logic [2:0] neg_on;

	// Bus decode and write strobes
	logic [2:0] act_wr;
	logic running;
	logic setup;
	logic wr_acc;
	logic wr_c0;
	logic wr_c1;
	logic hit;
	logic [31:0] rdata;

	// Status events and clears
	logic [2:0] sts_clr;
	logic [2:0] sts_set;

	// Complementary mode only runs with both counters started
	assign running = st_q.run0 && st_q.run1 && st_q.fcr.mode[`CPW_FCR_MODE_HI];
	assign setup = psel && !penable;
	// Access edge of an accepted, mapped write
	assign wr_acc = psel && penable && st_q.pready && pwrite && !st_q.pslverr;

	// Write strobes into the sub-blocks
	// Counter preload only while stopped; a live write would tear the pair
	always_comb begin
		wr_c0 = 1'b0;
		wr_c1 = 1'b0;
		act_wr = 3'h0;
		if (wr_acc) begin
			case (paddr)
				`CPW_OFS_CNT0: begin
					wr_c0 = !running;
				end
				`CPW_OFS_CNT1: begin
					wr_c1 = !running;
				end
				// Channels drop these themselves while running
				`CPW_OFS_ACT_A: begin
					act_wr[0] = 1'b1;
				end
				`CPW_OFS_ACT_B: begin
					act_wr[1] = 1'b1;
				end
				`CPW_OFS_ACT_C: begin
					act_wr[2] = 1'b1;
				end
				default: begin
					act_wr = 3'h0;
				end
			endcase
		end
	end

	// Counter pair; steps only while complementary mode runs
	cpw_counter_pair cpw_counter_pair_i (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.run(running),
		.period(st_q.period),
		.prescale(st_q.prescale),
		.wr_c0(wr_c0),
		.wr_c1(wr_c1),
		.wdata(pwdata[15:0]),
		.cnt(cnt),
		.evt(evt)
	);

	// One channel per phase
	for (genvar i = 0; i < `CPW_NCH; i++) begin : g_ch
		cpw_duty_chan cpw_duty_chan_i (
			.clk_sys(clk_sys),
			.reset_n(reset_n),
			.running(running),
			.sel_cm(st_q.fcr.mode == `CPW_MODE_XFER_CM),
			.buf_en(st_q.fcr.buf_sel[i]),
			.period(st_q.period),
			.buf_val(st_q.bufv[i]),
			.sw_wr(act_wr[i]),
			.wdata(pwdata[15:0]),
			.cnt(cnt),
			.evt(evt),
			.active(act[i]),
			.pos_on(pos_on[i]),
			.neg_on(neg_on[i])
		);
	end

	// Read decode, taken in the setup cycle
	always_comb begin
		rdata = '0;
		hit = 1'b1;
		case (paddr)
			// Control words
			`CPW_OFS_FCR: begin
				rdata[`CPW_FCR_MODE_HI:`CPW_FCR_MODE_LO] = st_q.fcr.mode;
				rdata[`CPW_FCR_LVL_POS] = st_q.fcr.lvl_pos;
				rdata[`CPW_FCR_LVL_NEG] = st_q.fcr.lvl_neg;
				rdata[`CPW_FCR_BSEL_HI:`CPW_FCR_BSEL_LO] = st_q.fcr.buf_sel;
			end
			`CPW_OFS_START: begin
				rdata[`CPW_START_RUN0] = st_q.run0;
				rdata[`CPW_START_RUN1] = st_q.run1;
			end
			// Status and interrupt mask
			`CPW_OFS_STATUS: begin
				rdata[`CPW_ST_W-1:0] = st_q.sts;
			end
			`CPW_OFS_MASK: begin
				rdata[`CPW_ST_W-1:0] = st_q.mask;
			end
			// Period and live counts
			`CPW_OFS_PERIOD: begin
				rdata[15:0] = st_q.period;
			end
			`CPW_OFS_CNT0: begin
				rdata[15:0] = cnt.c0;
			end
			`CPW_OFS_CNT1: begin
				rdata[15:0] = cnt.c1;
			end
			// Active compares show the last transfer or the last write made while stopped
			`CPW_OFS_ACT_A: begin
				rdata[15:0] = act[0];
			end
			`CPW_OFS_ACT_B: begin
				rdata[15:0] = act[1];
			end
			`CPW_OFS_ACT_C: begin
				rdata[15:0] = act[2];
			end
			// Buffers read back what software wrote
			`CPW_OFS_BUF_A: begin
				rdata[15:0] = st_q.bufv[0];
			end
			`CPW_OFS_BUF_B: begin
				rdata[15:0] = st_q.bufv[1];
			end
			`CPW_OFS_BUF_C: begin
				rdata[15:0] = st_q.bufv[2];
			end
			// Count divider
			`CPW_OFS_PRESCALE: begin
				rdata[15:0] = st_q.prescale;
			end
			// Unmapped: error response, data zero
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Sticky events; a set in the clearing cycle wins
	assign sts_set[`CPW_ST_PMATCH] = evt.cm;
	assign sts_set[`CPW_ST_UNDER] = evt.uf;
	assign sts_set[`CPW_ST_OVER] = evt.ovf;
	// A status write clears the bits written as one
	assign sts_clr = (wr_acc && paddr == `CPW_OFS_STATUS) ? pwdata[`CPW_ST_W-1:0] : 3'h0;

	// Next state: bus handshake, registers, pins
	always_comb begin
		st_d = st_q;
		// Zero wait states: answer in the first access cycle
		st_d.pready = setup;
		if (setup) begin
			st_d.prdata = pwrite ? 32'h0000_0000 : rdata;
			st_d.pslverr = !hit;
		end else begin
			st_d.pslverr = 1'b0;
		end
		if (wr_acc) begin
			case (paddr)
				`CPW_OFS_FCR: begin
					// Mode sequencing through 00b is software's duty
					st_d.fcr.mode = pwdata[`CPW_FCR_MODE_HI:`CPW_FCR_MODE_LO];
					st_d.fcr.lvl_pos = pwdata[`CPW_FCR_LVL_POS];
					st_d.fcr.lvl_neg = pwdata[`CPW_FCR_LVL_NEG];
					st_d.fcr.buf_sel = pwdata[`CPW_FCR_BSEL_HI:`CPW_FCR_BSEL_LO];
				end
				`CPW_OFS_START: begin
					// One run bit alone leaves the pair stopped
					st_d.run0 = pwdata[`CPW_START_RUN0];
					st_d.run1 = pwdata[`CPW_START_RUN1];
				end
				`CPW_OFS_MASK: begin
					st_d.mask = pwdata[`CPW_ST_W-1:0];
				end
				`CPW_OFS_PERIOD: begin
					// Period frozen while complementary mode runs
					if (!running) begin
						st_d.period = pwdata[15:0];
					end
				end
				`CPW_OFS_PRESCALE: begin
					if (!running) begin
						st_d.prescale = pwdata[15:0];
					end
				end
				// Buffers open at all times; select-bit order is software's
				`CPW_OFS_BUF_A: begin
					st_d.bufv[0] = pwdata[15:0];
				end
				`CPW_OFS_BUF_B: begin
					st_d.bufv[1] = pwdata[15:0];
				end
				`CPW_OFS_BUF_C: begin
					st_d.bufv[2] = pwdata[15:0];
				end
				// Status clears below; other words keep state
				default: begin
					st_d.period = st_q.period;
				end
			endcase
		end
		// Write-one-to-clear, with a new event taking precedence
		st_d.sts = (st_q.sts & ~sts_clr) | sts_set;
		// Built from the next state, so irq moves with the status bits
		st_d.irq = |(st_d.sts & st_d.mask);
		// Stopped pins fall back to the initial levels, not the last state
		for (int i = 0; i < `CPW_NCH; i++) begin
			if (running) begin
				// Active level is the inverse of the initial level
				st_d.pos[i] = pos_on[i] ^ st_q.fcr.lvl_pos;
				st_d.neg[i] = neg_on[i] ^ st_q.fcr.lvl_neg;
			end else begin
				st_d.pos[i] = st_q.fcr.lvl_pos;
				st_d.neg[i] = st_q.fcr.lvl_neg;
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			// Period resets to all ones, everything else to zero
			st_q <= '0;
			st_q.period <= `CPW_PERIOD_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output straight from the state register
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign irq = st_q.irq;
	assign pwm_pos = st_q.pos;
	assign pwm_neg = st_q.neg;

endmodule // cpw_top

`default_nettype wire
